// >>> hw/pulse_counter_pkg.sv
// constants shared by the fast pulse counter block
// assumes one 25 MHz clock; a scan tick enable is supplied by the caller
// Summary of operation
// - channel codes 200..220 step 4 select 0..5
// - enable rising edge starts the channel
// - parameters latched only at enable rise
// - format 0 updown,1 pulsedir,2 quad,3 quadx4
// - signed 32-bit preload loaded at start
// - external clear zeroes count when enabled
// - clear pins X0.0-0.3, X1.4, X1.5
// - count pins X0.8/9..X0.14/15, X1.0/1..X1.2/3
// - running count readable without stopping counter
// - valid one scan after enable; drops on fall/error
// - busy while enabled; cleared on fall/error
// - bad channel code sets error and fault code
// - count output updates only while valid
package pulse_counter_pkg;

  localparam int          CHANNELS        = 6;
  localparam logic [15:0] CODE_BASE       = 16'h00c8;   // 200
  localparam logic [15:0] CODE_STEP       = 16'h0004;
  localparam logic [15:0] CODE_LAST       = 16'h00dc;   // 220
  localparam logic [31:0] COUNT_RESET     = 32'h0000_0000;
  localparam logic [31:0] FAULT_NONE      = 32'h0000_0000;
  localparam logic [31:0] FAULT_CHANNEL   = 32'h0000_0001;
  localparam logic [31:0] FAULT_FORMAT    = 32'h0000_0002;
  localparam int          SCAN_TIME_US    = 1000;
  localparam int          CLOCK_MHZ       = 25;
  localparam int          SCAN_CYCLES     = SCAN_TIME_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    FMT_UP_DOWN_INPUTS  = 2'h0,
    FMT_PULSE_DIRECTION = 2'h1,
    FMT_QUADRATURE_X1   = 2'h2,
    FMT_QUADRATURE_X4   = 2'h3
  } pulse_format_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_WAIT    = 4'h2,
    ST_RUN     = 4'h4,
    ST_FAULT   = 4'h8
  } counter_state_t;

endpackage

// >>> hw/pulse_step_decode.sv
// turns one synchronised input pair into a count step
// assumes a, b already passed a two-flop synchroniser
`timescale 1ns/10ps
module pulse_step_decode (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] format,
  input  wire logic       in_a,
  input  wire logic       in_b,
  output logic            step_up,
  output logic            step_down
);

  logic a_q;
  logic b_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= in_a;
      b_q <= in_b;
    end
  end

  wire a_rise = in_a & ~a_q;
  wire b_rise = in_b & ~b_q;
  wire a_edge = in_a ^ a_q;
  wire b_edge = in_b ^ b_q;
  // x4: a change on a that leaves a!=b means a leads, which counts up as in x1
  wire q4_up   = (a_edge & (in_a ^ in_b)) | (b_edge & ~(in_a ^ in_b));
  wire q4_down = (a_edge & ~(in_a ^ in_b)) | (b_edge & (in_a ^ in_b));
  // x1: one count per cycle, on the a rising edge only
  wire q1_up   = a_rise & ~in_b;
  wire q1_down = a_rise & in_b;

  always_comb begin
    step_up   = 1'b0;
    step_down = 1'b0;
    case (format)
      pulse_counter_pkg::FMT_UP_DOWN_INPUTS: begin
        step_up   = a_rise;
        step_down = b_rise;
      end
      pulse_counter_pkg::FMT_PULSE_DIRECTION: begin
        step_up   = a_rise & ~in_b;
        step_down = a_rise & in_b;
      end
      pulse_counter_pkg::FMT_QUADRATURE_X1: begin
        step_up   = q1_up;
        step_down = q1_down;
      end
      pulse_counter_pkg::FMT_QUADRATURE_X4: begin
        step_up   = q4_up & ~(a_edge & b_edge);
        step_down = q4_down & ~(a_edge & b_edge);
      end
      default: begin
        step_up   = 1'b0;
        step_down = 1'b0;
      end
    endcase
  end

endmodule

// >>> hw/fast_pulse_counter_block.sv
// single high-speed pulse counter channel with six selectable pin sets
// assumes X pins are asynchronous; SCAN_TICK is a one-cycle pulse per scan
`timescale 1ns/10ps
module fast_pulse_counter_block (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        SCAN_TICK,
  input  wire logic        ENABLE,
  input  wire logic [15:0] CHANNEL_CODE,
  input  wire logic        EXTERNAL_CLEAR_ENABLE,
  input  wire logic [1:0]  PULSE_FORMAT_SELECT,
  input  wire logic [31:0] PRELOAD_VALUE,
  input  wire logic [15:0] X0_PINS,
  input  wire logic [15:0] X1_PINS,
  output logic             VALID,
  output logic             BUSY,
  output logic             ERROR,
  output logic [31:0]      FAULT_CODE,
  output logic [31:0]      COUNT_OUTPUT
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [31:0] pins_meta_q;
  logic [31:0] pins_q;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pins_meta_q <= 32'h0000_0000;
      pins_q      <= 32'h0000_0000;
    end else begin
      pins_meta_q <= {X1_PINS, X0_PINS};
      pins_q      <= pins_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // channel decode and pin routing
  // ---------------------------------------------------------------
  function automatic logic [3:0] decode_channel(input logic [15:0] code);
    logic [15:0] off;
    off = code - pulse_counter_pkg::CODE_BASE;
    if (code < pulse_counter_pkg::CODE_BASE || code > pulse_counter_pkg::CODE_LAST || off[1:0] != 2'h0)
      decode_channel = 4'hf;
    else
      decode_channel = {1'b0, off[4:2]};
  endfunction

  wire [15:0] x0 = pins_q[15:0];
  wire [15:0] x1 = pins_q[31:16];
  // per-channel pin tables, index = channel
  wire [5:0] pin_a     = {x1[2], x1[0], x0[14], x0[12], x0[10], x0[8]};
  wire [5:0] pin_b     = {x1[3], x1[1], x0[15], x0[13], x0[11], x0[9]};
  wire [5:0] pin_clear = {x1[5], x1[4], x0[3], x0[2], x0[1], x0[0]};

  wire [3:0] code_index = decode_channel(CHANNEL_CODE);
  wire       code_bad   = code_index == 4'hf;
  // a bad code parks the pin select on channel 0 so no table is indexed past its end
  wire [2:0] chan_idx   = code_bad ? 3'h0 : code_index[2:0];

  // ---------------------------------------------------------------
  // parameter latch
  // ---------------------------------------------------------------
  logic        enable_q;
  logic [2:0]  chan_q;
  logic [1:0]  format_q;
  logic        clear_en_q;
  logic [31:0] count_q;
  logic [31:0] count_d;

  wire enable_rise = ENABLE & ~enable_q;
  wire enable_fall = ~ENABLE & enable_q;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      enable_q   <= 1'b0;
      chan_q     <= 3'h0;
      format_q   <= 2'h0;
      clear_en_q <= 1'b0;
    end else begin
      enable_q <= ENABLE;
      if (enable_rise) begin
        chan_q     <= chan_idx;
        format_q   <= PULSE_FORMAT_SELECT;
        clear_en_q <= EXTERNAL_CLEAR_ENABLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // step decoder on the selected pair
  // ---------------------------------------------------------------
  wire sel_a     = pin_a[chan_q];
  wire sel_b     = pin_b[chan_q];
  wire sel_clear = pin_clear[chan_q];
  logic step_up;
  logic step_down;

  pulse_step_decode u_decode (
    .clk       (CLOCK),
    .rst       (RST),
    .format    (format_q),
    .in_a      (sel_a),
    .in_b      (sel_b),
    .step_up   (step_up),
    .step_down (step_down)
  );

  // ---------------------------------------------------------------
  // control state machine
  // ---------------------------------------------------------------
  pulse_counter_pkg::counter_state_t state_q;
  pulse_counter_pkg::counter_state_t state_d;
  logic [31:0] fault_d;
  logic [31:0] fault_q;

  // pulses count from the start edge on; valid only follows the next scan tick
  always_comb begin
    state_d = state_q;
    fault_d = fault_q;
    case (state_q)
      pulse_counter_pkg::ST_IDLE: begin
        if (enable_rise) begin
          if (code_bad) begin
            state_d = pulse_counter_pkg::ST_FAULT;
            fault_d = pulse_counter_pkg::FAULT_CHANNEL;
          end else begin
            state_d = pulse_counter_pkg::ST_WAIT;
          end
        end
      end
      pulse_counter_pkg::ST_WAIT: begin
        if (!ENABLE)
          state_d = pulse_counter_pkg::ST_IDLE;
        else if (SCAN_TICK)
          state_d = pulse_counter_pkg::ST_RUN;
      end
      pulse_counter_pkg::ST_RUN: begin
        if (!ENABLE)
          state_d = pulse_counter_pkg::ST_IDLE;
      end
      pulse_counter_pkg::ST_FAULT: begin
        if (enable_fall) begin
          state_d = pulse_counter_pkg::ST_IDLE;
          fault_d = pulse_counter_pkg::FAULT_NONE;
        end
      end
      default: begin
        state_d = pulse_counter_pkg::ST_IDLE;
        fault_d = pulse_counter_pkg::FAULT_NONE;
      end
    endcase
  end

  wire counting = (state_q == pulse_counter_pkg::ST_WAIT) || (state_q == pulse_counter_pkg::ST_RUN);
  wire run_next = state_d == pulse_counter_pkg::ST_RUN;
  wire busy_next = (state_d == pulse_counter_pkg::ST_WAIT) || run_next;
  wire do_clear  = counting & clear_en_q & sel_clear;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    if (enable_rise)
      count_d = PRELOAD_VALUE;
    else if (do_clear)
      count_d = pulse_counter_pkg::COUNT_RESET;
    else if (counting && step_up && !step_down)
      count_d = count_q + 32'h0000_0001;
    else if (counting && step_down && !step_up)
      count_d = count_q - 32'h0000_0001;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q      <= pulse_counter_pkg::ST_IDLE;
      fault_q      <= pulse_counter_pkg::FAULT_NONE;
      count_q      <= pulse_counter_pkg::COUNT_RESET;
      VALID        <= 1'b0;
      BUSY         <= 1'b0;
      ERROR        <= 1'b0;
      FAULT_CODE   <= pulse_counter_pkg::FAULT_NONE;
      COUNT_OUTPUT <= pulse_counter_pkg::COUNT_RESET;
    end else begin
      state_q    <= state_d;
      fault_q    <= fault_d;
      count_q    <= count_d;
      VALID      <= run_next;
      BUSY       <= busy_next;
      ERROR      <= state_d == pulse_counter_pkg::ST_FAULT;
      FAULT_CODE <= fault_d;
      if (run_next)
        COUNT_OUTPUT <= count_d;
    end
  end

endmodule

// >>> tb/pulse_counter_properties.sv
// assertions on the fast pulse counter block ports
// assumes one clock and the synchronous active-high reset
`timescale 1ns/10ps
module pulse_counter_checker (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        SCAN_TICK,
  input wire logic        ENABLE,
  input wire logic [15:0] CHANNEL_CODE,
  input wire logic        VALID,
  input wire logic        BUSY,
  input wire logic        ERROR,
  input wire logic [31:0] FAULT_CODE,
  input wire logic [31:0] COUNT_OUTPUT
);
  wire code_ok = CHANNEL_CODE[1:0] == 2'h0 && CHANNEL_CODE >= pulse_counter_pkg::CODE_BASE
    && CHANNEL_CODE <= pulse_counter_pkg::CODE_LAST;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_good;
    !ENABLE ##1 ENABLE && code_ok;
  endsequence
  sequence s_bad;
    !ENABLE ##1 ENABLE && !code_ok;
  endsequence
  chk_start_busy: assert property (s_good |-> ##2 BUSY && !ERROR)
    else $error("busy missing after start");
  chk_start_fault: assert property (s_bad |-> ##2 ERROR && !BUSY)
    else $error("error missing for bad code");
  chk_drop_outputs: assert property (!ENABLE |=> !BUSY && !VALID && !ERROR)
    else $error("outputs held after enable fell");
  chk_busy_holds: assert property (BUSY && ENABLE |=> BUSY)
    else $error("busy lost while enabled");
  chk_valid_tick: assert property (BUSY && ENABLE && SCAN_TICK |=> VALID)
    else $error("valid missing after scan");
  chk_valid_cause: assert property ($rose(VALID) |-> $past(SCAN_TICK) && $past(BUSY))
    else $error("valid rose without scan");
  chk_error_fault: assert property (ERROR |-> !BUSY && !VALID && FAULT_CODE == 32'h1)
    else $error("error state inconsistent");
  chk_fault_idle: assert property (!ERROR |-> FAULT_CODE == 32'h0)
    else $error("fault code without error");
  chk_count_frozen: assert property (!VALID && !$past(VALID) |-> $stable(COUNT_OUTPUT))
    else $error("count moved while not valid");
endmodule
bind fast_pulse_counter_block pulse_counter_checker pulse_counter_checker_inst (.*);

// >>> tb/pulse_source_model.sv
// pulse source standing in for an encoder or pulse train
// assumes step is a one-cycle request spaced a few cycles apart
`timescale 1ns/10ps
module pulse_source_model (
  input  wire logic       clk,
  input  wire logic       step,
  input  wire logic       dir_down,
  input  wire logic [1:0] fmt,
  input  wire logic [2:0] ch,
  input  wire logic       clr,
  output logic [15:0]     x0,
  output logic [15:0]     x1
);
  logic [1:0] ph = 2'h0;
  logic       ua = 1'b0;
  logic       ub = 1'b0;
  wire  [5:0] c = {3'h0, ch};
  // gray walk: a leads b when counting up
  always @(posedge clk) begin
    if (step && fmt[1]) ph <= dir_down ? ph - 2'h1 : ph + 2'h1;
    else if (step && dir_down && !fmt[0]) ub <= ~ub;
    else if (step) ua <= ~ua;
  end
  wire a = fmt[1] ? ph[1] ^ ph[0] : ua;
  wire b = fmt[1] ? ph[1] : fmt[0] ? dir_down : ub;
  // unselected terminals sit low so a wrong pair cannot count
  assign {x1, x0} = ({30'h0, b, a} << (2 * c + 8)) | (32'(clr) << (c < 4 ? c : c + 16));
endmodule

// >>> tb/tb.sv
// self-checking bench for the fast pulse counter block
// assumes the pulse source model and the bound checker
`timescale 1ns/10ps
module tb;
  logic        clock = 1'b0, rst = 1'b1, tick = 1'b0, enable = 1'b0, clr_en = 1'b0;
  logic        step = 1'b0, down = 1'b0, clr = 1'b0, valid, busy, error;
  logic [1:0]  fsel = 2'h0, fmt = 2'h0;
  logic [2:0]  ch = 3'h0;
  logic [15:0] code = 16'h00c8, x0, x1;
  logic [31:0] pre = 32'h0, fault, count;
  int          num_errors = 0, check_count = 0, cycles = 0;
  fast_pulse_counter_block fast_pulse_counter_block_inst (.CLOCK(clock), .RST(rst), .SCAN_TICK(tick),
    .ENABLE(enable), .CHANNEL_CODE(code), .EXTERNAL_CLEAR_ENABLE(clr_en), .PULSE_FORMAT_SELECT(fsel),
    .PRELOAD_VALUE(pre), .X0_PINS(x0), .X1_PINS(x1), .VALID(valid), .BUSY(busy), .ERROR(error),
    .FAULT_CODE(fault), .COUNT_OUTPUT(count));
  pulse_source_model pulse_source_model_inst (.clk(clock), .step(step), .dir_down(down), .fmt(fmt),
    .ch(ch), .clr(clr), .x0(x0), .x1(x1));
  initial begin
    forever #20 clock = ~clock;
  end
  // scan period cut to 16 cycles to keep the run short
  always begin
    @(posedge clock);
    #1;
    cycles++;
    tick = cycles % 16 == 0;
    if (cycles == 10000) begin
      num_errors++;
      finish_test();
    end
  end
  // ------------
  // shared tasks
  // ------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic start(input logic [15:0] c, input logic [31:0] p);
    code = c;
    pre = p;
    enable = 1'b1;
    wait_n(1);
  endtask
  task automatic stop();
    enable = 1'b0;
    wait_n(1);
    cmp("busy_valid_low", 32'h0, {30'h0, busy, valid});
  endtask
  task automatic wait_valid();
    for (int i = 0; i < 40 && valid !== 1'b1; i++) wait_n(1);
    cmp("valid_up", 32'h1, {31'h0, valid});
  endtask
  task automatic pulses(input int n, input logic dn);
    down = dn;
    repeat (n) begin
      step = 1'b1;
      wait_n(1);
      step = 1'b0;
      wait_n(3);
    end
    wait_n(8);
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic t_channels();
    logic [31:0] e;
    int          d;
    for (int c = 0; c < 6; c++) begin
      for (int f = 0; f < 4; f++) begin
        ch = 3'(c);
        fmt = 2'(f);
        fsel = 2'(f);
        clr_en = fsel[0];
        d = f == 3 ? 1 : f == 2 ? 4 : 2;
        e = 32'hffff_fff0 + 32'(c);
        start(16'h00c8 + 16'(4 * c), e);
        wait_valid();
        cmp("preload", e, count);
        pulses(8, 1'b0);
        e = e + 32'(8 / d);
        cmp("count_up", e, count);
        pulses(4, 1'b1);
        e = e - 32'(4 / d);
        cmp("count_down", e, count);
        clr = 1'b1;
        wait_n(6);
        cmp("ext_clear", clr_en ? 32'h0 : e, count);
        clr = 1'b0;
        stop();
      end
    end
  endtask
  task automatic t_bad();
    logic [15:0] bad [3] = '{16'h00ca, 16'h00e0, 16'h0000};
    foreach (bad[i]) begin
      start(bad[i], 32'h5);
      wait_n(1);
      cmp("fault_state", 32'h4, {29'h0, error, busy, valid});
      cmp("fault_code", 32'h1, fault);
      stop();
      cmp("fault_clear", 32'h0, {fault[30:0], error});
    end
  endtask
  task automatic t_latch();
    ch = 3'h0;
    fmt = 2'h3;
    fsel = 2'h3;
    clr_en = 1'b0;
    start(16'h00c8, 32'h7);
    wait_valid();
    code = 16'h00ca;
    fsel = 2'h0;
    pre = 32'h0;
    clr_en = 1'b1;
    pulses(4, 1'b0);
    clr = 1'b1;
    wait_n(6);
    clr = 1'b0;
    cmp("latched", 32'hb, count);
    cmp("no_error", 32'h0, {31'h0, error});
    enable = 1'b0;
    wait_n(1);
    ch = 3'h5;
    fmt = 2'h0;
    start(16'h00dc, 32'h8000_0000);
    wait_valid();
    cmp("restart", 32'h8000_0000, count);
    stop();
    pulses(4, 1'b0);
    cmp("frozen", 32'h8000_0000, count);
  endtask
  initial begin
    wait_n(10);
    rst = 1'b0;
    wait_n(1);
    cmp("reset_flags", 32'h0, {29'h0, valid, busy, error});
    cmp("reset_count", 32'h0, count | fault);
    t_channels();
    t_bad();
    t_latch();
    finish_test();
  end
endmodule
